// ==== core/cid_pkg.sv ====
// constants and types of the 14-bit instruction decoder
// assumes one core clock; program memory and datapath share it
package cid_pkg;

    typedef enum logic [5:0] {
        OP_NO_OPERATION, OP_SW_RESET, OP_SUB_RETURN, OP_INTERRUPT_RETURN,
        OP_SUBROUTINE_CALL_ACC, OP_RELATIVE_BRANCH_ACC, OP_INDIRECT_READ_ACC, OP_INDIRECT_WRITE_ACC,
        OP_LOAD_BANK_SELECT, OP_LOAD_OPTION, OP_STANDBY, OP_WATCHDOG_CLEAR,
        OP_LOAD_PIN_DIRECTION, OP_MOVE_ACC_FILE, OP_CLEAR_ACC, OP_CLEAR_FILE,
        OP_SUB_ACC_FILE, OP_DEC_FILE, OP_OR_ACC_FILE, OP_AND_ACC_FILE,
        OP_XOR_ACC_FILE, OP_ADD_ACC_FILE, OP_MOVE_FILE, OP_COMPLEMENT_FILE,
        OP_INC_FILE, OP_DEC_SKIP_ZERO, OP_ROTATE_RIGHT_VIA_CARRY, OP_ROTATE_LEFT_VIA_CARRY,
        OP_SWAP_NIBBLES, OP_INC_SKIP_ZERO, OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE,
        OP_BIT_TEST_SKIP_CLEAR, OP_BIT_TEST_SKIP_SET, OP_SUBROUTINE_CALL, OP_ABSOLUTE_JUMP,
        OP_LOAD_LITERAL_ACC, OP_POINTER_ADD_LITERAL, OP_LOAD_PC_HIGH_LATCH, OP_RELATIVE_BRANCH,
        OP_RETURN_WITH_LITERAL, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ARITH_SHIFT_RIGHT_FILE,
        OP_OR_LITERAL_ACC, OP_AND_LITERAL_ACC, OP_XOR_LITERAL_ACC, OP_SUB_FILE_BORROW,
        OP_SUB_ACC_FROM_LITERAL, OP_ADD_ACC_FILE_CARRY, OP_ADD_LITERAL_ACC, OP_INDEXED_READ_ACC,
        OP_INDEXED_WRITE_ACC
    } cid_op_t;

    // gray along idle -> exec -> stall; the stall -> idle step flips both bits
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_STALL = 2'b11
    } cid_state_t;

    localparam logic [6:0]  FILE_INDIRECT_PORT0 = 7'h00;
    localparam logic [6:0]  FILE_INDIRECT_PORT1 = 7'h01;
    localparam logic [1:0]  CYC_SINGLE          = 2'h1;
    localparam logic [1:0]  CYC_TRANSFER        = 2'h2;
    localparam logic [11:0] APB_CTRL_OFFSET     = 12'h000;
    localparam logic [11:0] APB_STATUS_OFFSET   = 12'h004;
    localparam int          CTRL_ENABLE_BIT     = 0;
    localparam logic        CTRL_ENABLE_RESET   = 1'b1;
    localparam int          STAT_CYC_LSB        = 8;
    localparam int          STAT_BUSY_BIT       = 16;

endpackage

// ==== core/cid_decoder.sv ====
// 14-bit instruction decoder with cycle sequencing and a small apb slave
// assumes program memory and datapath run on i_core_clk; no synchronisers needed
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cid_decoder
    import cid_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // instruction fetch
    input  wire logic        i_instr_valid,
    input  wire logic [13:0] i_instr,
    output logic             o_ready,
    // datapath feedback
    input  wire logic        i_fsr0_msb,
    input  wire logic        i_fsr1_msb,
    input  wire logic        i_cond_true,
    // decoded controls
    output logic             o_exec,
    output logic             o_stall,
    output logic [5:0]       o_op,
    output logic             o_dest_file,
    output logic [6:0]       o_file_addr,
    output logic [2:0]       o_bit_sel,
    output logic [10:0]      o_literal,
    output logic             o_ptr_sel,
    output logic [1:0]       o_ptr_mode,
    output logic [15:0]      o_ptr_offset,
    output logic             o_cond,
    output logic             o_upd_c,
    output logic             o_upd_dc,
    output logic             o_upd_z,
    output logic             o_upd_stat,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    typedef struct packed {
        cid_state_t  state;
        logic        ready;
        logic        exec;
        logic        stall;
        logic [5:0]  op;
        logic        dest;
        logic [6:0]  faddr;
        logic [2:0]  bsel;
        logic [10:0] lit;
        logic        psel_n;
        logic [1:0]  pmode;
        logic [15:0] poff;
        logic        cond;
        logic        uc;
        logic        udc;
        logic        uz;
        logic        ustat;
        logic [1:0]  remain;
        logic [1:0]  total;
        logic [1:0]  last_cyc;
        logic        enable;
        logic [31:0] rdata;
        logic        pready;
        logic        perr;
    } cid_regs_t;

    cid_regs_t r_ff;
    cid_regs_t nxt_r;

    // ------------------------------------------------------------
    // opcode match
    // ------------------------------------------------------------
    cid_op_t dec_op;
    always_comb
    begin
        casez (i_instr)
            14'b00_0000_0000_0000: dec_op = OP_NO_OPERATION;
            14'b00_0000_0000_0001: dec_op = OP_SW_RESET;
            14'b00_0000_0000_1000: dec_op = OP_SUB_RETURN;
            14'b00_0000_0000_1001: dec_op = OP_INTERRUPT_RETURN;
            14'b00_0000_0000_1010: dec_op = OP_SUBROUTINE_CALL_ACC;
            14'b00_0000_0000_1011: dec_op = OP_RELATIVE_BRANCH_ACC;
            14'b00_0000_0001_0???: dec_op = OP_INDIRECT_READ_ACC;
            14'b00_0000_0001_1???: dec_op = OP_INDIRECT_WRITE_ACC;
            14'b00_0000_001?_????: dec_op = OP_LOAD_BANK_SELECT;
            14'b00_0000_0110_0010: dec_op = OP_LOAD_OPTION;
            14'b00_0000_0110_0011: dec_op = OP_STANDBY;
            14'b00_0000_0110_0100: dec_op = OP_WATCHDOG_CLEAR;
            14'b00_0000_0110_0???: dec_op = OP_LOAD_PIN_DIRECTION;
            14'b00_0000_1???_????: dec_op = OP_MOVE_ACC_FILE;
            14'b00_0001_0000_00??: dec_op = OP_CLEAR_ACC;
            14'b00_0001_1???_????: dec_op = OP_CLEAR_FILE;
            14'b00_0010_????_????: dec_op = OP_SUB_ACC_FILE;
            14'b00_0011_????_????: dec_op = OP_DEC_FILE;
            14'b00_0100_????_????: dec_op = OP_OR_ACC_FILE;
            14'b00_0101_????_????: dec_op = OP_AND_ACC_FILE;
            14'b00_0110_????_????: dec_op = OP_XOR_ACC_FILE;
            14'b00_0111_????_????: dec_op = OP_ADD_ACC_FILE;
            14'b00_1000_????_????: dec_op = OP_MOVE_FILE;
            14'b00_1001_????_????: dec_op = OP_COMPLEMENT_FILE;
            14'b00_1010_????_????: dec_op = OP_INC_FILE;
            14'b00_1011_????_????: dec_op = OP_DEC_SKIP_ZERO;
            14'b00_1100_????_????: dec_op = OP_ROTATE_RIGHT_VIA_CARRY;
            14'b00_1101_????_????: dec_op = OP_ROTATE_LEFT_VIA_CARRY;
            14'b00_1110_????_????: dec_op = OP_SWAP_NIBBLES;
            14'b00_1111_????_????: dec_op = OP_INC_SKIP_ZERO;
            14'b01_00??_????_????: dec_op = OP_BIT_CLEAR_FILE;
            14'b01_01??_????_????: dec_op = OP_BIT_SET_FILE;
            14'b01_10??_????_????: dec_op = OP_BIT_TEST_SKIP_CLEAR;
            14'b01_11??_????_????: dec_op = OP_BIT_TEST_SKIP_SET;
            14'b10_0???_????_????: dec_op = OP_SUBROUTINE_CALL;
            14'b10_1???_????_????: dec_op = OP_ABSOLUTE_JUMP;
            14'b11_0000_????_????: dec_op = OP_LOAD_LITERAL_ACC;
            14'b11_0001_0???_????: dec_op = OP_POINTER_ADD_LITERAL;
            14'b11_0001_1???_????: dec_op = OP_LOAD_PC_HIGH_LATCH;
            14'b11_001?_????_????: dec_op = OP_RELATIVE_BRANCH;
            14'b11_0100_????_????: dec_op = OP_RETURN_WITH_LITERAL;
            14'b11_0101_????_????: dec_op = OP_LOGIC_SHIFT_LEFT;
            14'b11_0110_????_????: dec_op = OP_LOGIC_SHIFT_RIGHT;
            14'b11_0111_????_????: dec_op = OP_ARITH_SHIFT_RIGHT_FILE;
            14'b11_1000_????_????: dec_op = OP_OR_LITERAL_ACC;
            14'b11_1001_????_????: dec_op = OP_AND_LITERAL_ACC;
            14'b11_1010_????_????: dec_op = OP_XOR_LITERAL_ACC;
            14'b11_1011_????_????: dec_op = OP_SUB_FILE_BORROW;
            14'b11_1100_????_????: dec_op = OP_SUB_ACC_FROM_LITERAL;
            14'b11_1101_????_????: dec_op = OP_ADD_ACC_FILE_CARRY;
            14'b11_1110_????_????: dec_op = OP_ADD_LITERAL_ACC;
            14'b11_1111_0???_????: dec_op = OP_INDEXED_READ_ACC;
            14'b11_1111_1???_????: dec_op = OP_INDEXED_WRITE_ACC;
            default:               dec_op = OP_NO_OPERATION;
        endcase
    end

    // ------------------------------------------------------------
    // per-opcode attributes
    // ------------------------------------------------------------
    logic       a_file;
    logic       a_ptr;
    logic       a_cond;
    logic       a_uc;
    logic       a_udc;
    logic       a_uz;
    logic       a_ustat;
    logic [1:0] a_cyc;
    always_comb
    begin
        a_file  = 1'b0;
        a_ptr   = 1'b0;
        a_cond  = 1'b0;
        a_uc    = 1'b0;
        a_udc   = 1'b0;
        a_uz    = 1'b0;
        a_ustat = 1'b0;
        a_cyc   = CYC_SINGLE;
        case (dec_op)
            OP_ADD_ACC_FILE, OP_SUB_ACC_FILE, OP_SUB_FILE_BORROW, OP_ADD_ACC_FILE_CARRY:
            begin
                a_file = 1'b1;
                a_uc   = 1'b1;
                a_udc  = 1'b1;
                a_uz   = 1'b1;
            end
            OP_ARITH_SHIFT_RIGHT_FILE, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT:
            begin
                a_file = 1'b1;
                a_uc   = 1'b1;
                a_uz   = 1'b1;
            end
            OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY:
            begin
                a_file = 1'b1;
                a_uc   = 1'b1;
            end
            OP_XOR_ACC_FILE, OP_AND_ACC_FILE, OP_OR_ACC_FILE, OP_MOVE_FILE, OP_COMPLEMENT_FILE,
            OP_DEC_FILE, OP_INC_FILE, OP_CLEAR_FILE:
            begin
                a_file = 1'b1;
                a_uz   = 1'b1;
            end
            OP_MOVE_ACC_FILE, OP_SWAP_NIBBLES, OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE:
            begin
                a_file = 1'b1;
            end
            OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_BIT_TEST_SKIP_CLEAR, OP_BIT_TEST_SKIP_SET:
            begin
                a_file = 1'b1;
                a_cond = 1'b1;
            end
            OP_CLEAR_ACC, OP_OR_LITERAL_ACC, OP_XOR_LITERAL_ACC, OP_AND_LITERAL_ACC:
            begin
                a_uz = 1'b1;
            end
            OP_SUB_ACC_FROM_LITERAL, OP_ADD_LITERAL_ACC:
            begin
                a_uc  = 1'b1;
                a_udc = 1'b1;
                a_uz  = 1'b1;
            end
            OP_RELATIVE_BRANCH, OP_RELATIVE_BRANCH_ACC, OP_SUBROUTINE_CALL, OP_ABSOLUTE_JUMP,
            OP_SUBROUTINE_CALL_ACC, OP_SUB_RETURN, OP_INTERRUPT_RETURN, OP_RETURN_WITH_LITERAL:
            begin
                a_cyc = CYC_TRANSFER;
            end
            OP_WATCHDOG_CLEAR, OP_STANDBY:
            begin
                a_ustat = 1'b1;
            end
            OP_INDIRECT_READ_ACC, OP_INDEXED_READ_ACC:
            begin
                a_ptr = 1'b1;
                a_uz  = 1'b1;
            end
            OP_INDIRECT_WRITE_ACC, OP_INDEXED_WRITE_ACC:
            begin
                a_ptr = 1'b1;
            end
            default:
            begin
                a_cyc = CYC_SINGLE;
            end
        endcase
    end

    // pointer bit sits at bit 2 for modifier forms, bit 6 for indexed and add forms
    logic ptr_n;
    logic slow_ptr;
    assign ptr_n    = (dec_op == OP_INDIRECT_READ_ACC || dec_op == OP_INDIRECT_WRITE_ACC) ? i_instr[2] : i_instr[6];
    assign slow_ptr = (a_file && i_instr[6:0] == FILE_INDIRECT_PORT0 && i_fsr0_msb)
                   || (a_file && i_instr[6:0] == FILE_INDIRECT_PORT1 && i_fsr1_msb)
                   || (a_ptr && (ptr_n ? i_fsr1_msb : i_fsr0_msb));

    // ------------------------------------------------------------
    // sequencer and apb
    // ------------------------------------------------------------
    logic       take;
    logic [1:0] after_exec;
    logic       apb_acc;
    always_comb
    begin
        nxt_r      = r_ff;
        take       = (r_ff.state == ST_IDLE) && r_ff.ready && i_instr_valid;
        after_exec = r_ff.remain + {1'b0, (r_ff.cond && i_cond_true)};
        apb_acc    = psel && penable && !r_ff.pready;
        case (r_ff.state)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt_r.state  = ST_EXEC;
                    nxt_r.ready  = 1'b0;
                    nxt_r.exec   = 1'b1;
                    // a disabled decoder turns every word into a no operation
                    nxt_r.op     = r_ff.enable ? dec_op : OP_NO_OPERATION;
                    nxt_r.dest   = i_instr[7];
                    nxt_r.faddr  = i_instr[6:0];
                    nxt_r.bsel   = i_instr[9:7];
                    nxt_r.lit    = i_instr[10:0];
                    nxt_r.psel_n = ptr_n;
                    nxt_r.pmode  = i_instr[1:0];
                    nxt_r.poff   = {{10{i_instr[5]}}, i_instr[5:0]};
                    nxt_r.cond   = r_ff.enable && a_cond;
                    nxt_r.uc     = r_ff.enable && a_uc;
                    nxt_r.udc    = r_ff.enable && a_udc;
                    nxt_r.uz     = r_ff.enable && a_uz;
                    nxt_r.ustat  = r_ff.enable && a_ustat;
                    nxt_r.remain = r_ff.enable ? a_cyc - CYC_SINGLE + {1'b0, slow_ptr} : 2'h0;
                end
            end
            ST_EXEC:
            begin
                nxt_r.exec  = 1'b0;
                nxt_r.total = after_exec + CYC_SINGLE;
                if (after_exec == 2'h0)
                begin
                    nxt_r.state    = ST_IDLE;
                    nxt_r.ready    = 1'b1;
                    nxt_r.last_cyc = CYC_SINGLE;
                end
                else
                begin
                    nxt_r.state  = ST_STALL;
                    nxt_r.stall  = 1'b1;
                    nxt_r.remain = after_exec - 2'h1;
                end
            end
            ST_STALL:
            begin
                if (r_ff.remain == 2'h0)
                begin
                    nxt_r.state    = ST_IDLE;
                    nxt_r.stall    = 1'b0;
                    nxt_r.ready    = 1'b1;
                    nxt_r.last_cyc = r_ff.total;
                end
                else
                begin
                    nxt_r.remain = r_ff.remain - 2'h1;
                end
            end
            default:
            begin
                nxt_r.state = ST_IDLE;
            end
        endcase

        // one wait state: pready rises in the second access cycle
        nxt_r.pready = apb_acc;
        nxt_r.perr   = 1'b0;
        if (apb_acc)
        begin
            nxt_r.rdata = 32'h0000_0000;
            if (paddr == APB_CTRL_OFFSET)
            begin
                nxt_r.rdata[CTRL_ENABLE_BIT] = r_ff.enable;
            end
            else if (paddr == APB_STATUS_OFFSET)
            begin
                nxt_r.rdata[5:0]                        = r_ff.op;
                nxt_r.rdata[STAT_CYC_LSB+1:STAT_CYC_LSB] = r_ff.last_cyc;
                nxt_r.rdata[STAT_BUSY_BIT]              = !r_ff.ready;
            end
            else
            begin
                nxt_r.perr = 1'b1;
            end
        end
        // the write lands on the edge that completes the transfer, with pready seen high
        if (psel && penable && r_ff.pready && pwrite && paddr == APB_CTRL_OFFSET)
        begin
            nxt_r.enable = pwdata[CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            r_ff        <= '0;
            r_ff.state  <= ST_IDLE;
            r_ff.ready  <= 1'b1;
            r_ff.enable <= CTRL_ENABLE_RESET;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign o_ready      = r_ff.ready;
    assign o_exec       = r_ff.exec;
    assign o_stall      = r_ff.stall;
    assign o_op         = r_ff.op;
    assign o_dest_file  = r_ff.dest;
    assign o_file_addr  = r_ff.faddr;
    assign o_bit_sel    = r_ff.bsel;
    assign o_literal    = r_ff.lit;
    assign o_ptr_sel    = r_ff.psel_n;
    assign o_ptr_mode   = r_ff.pmode;
    assign o_ptr_offset = r_ff.poff;
    assign o_cond       = r_ff.cond;
    assign o_upd_c      = r_ff.uc;
    assign o_upd_dc     = r_ff.udc;
    assign o_upd_z      = r_ff.uz;
    assign o_upd_stat   = r_ff.ustat;
    assign prdata       = r_ff.rdata;
    assign pready       = r_ff.pready;
    assign pslverr      = r_ff.perr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_transfer_two_cycles: assert property (
        o_exec && o_op == OP_ABSOLUTE_JUMP && r_ff.remain == 2'h1 |=> o_stall ##1 o_ready && !o_stall)
        else $error("jump did not take two cycles");
    chk_skip_adds_cycle: assert property (
        o_exec && o_cond && i_cond_true && r_ff.remain == 2'h0 |=> o_stall ##1 o_ready)
        else $error("taken skip did not add one idle cycle");
    chk_no_skip_single: assert property (
        o_exec && o_cond && !i_cond_true && r_ff.remain == 2'h0 |=> o_ready && !o_stall)
        else $error("untaken skip stalled");
    chk_slow_port_extra: assert property (
        take && r_ff.enable && a_file && !a_cond && a_cyc == CYC_SINGLE && i_fsr0_msb
        && i_instr[6:0] == FILE_INDIRECT_PORT0 |=> o_exec ##1 o_stall ##1 o_ready)
        else $error("indirect port with pointer msb lacked extra cycle");
    chk_dest_bit: assert property (
        o_exec && o_op == OP_ADD_ACC_FILE_CARRY |-> o_dest_file == $past(i_instr[7]))
        else $error("destination bit not carried");
    chk_carry_add_flags: assert property (
        o_exec && o_op == OP_ADD_ACC_FILE_CARRY |-> o_upd_c && o_upd_dc && o_upd_z)
        else $error("carry add flags wrong");
    chk_pointer_sign: assert property (
        o_exec && o_op == OP_POINTER_ADD_LITERAL |-> o_ptr_offset == {{10{$past(i_instr[5])}}, $past(i_instr[5:0])})
        else $error("pointer literal not sign extended");
    chk_unknown_quiet: assert property (
        take && r_ff.enable && i_instr == 14'h0002 |=> o_exec && o_op == OP_NO_OPERATION
        && !o_upd_c && !o_upd_z && !o_upd_dc ##1 o_ready)
        else $error("unknown word was not a quiet no operation");
    chk_status_touch: assert property (
        o_exec && (o_op == OP_WATCHDOG_CLEAR || o_op == OP_STANDBY) |-> o_upd_stat ##1 o_ready)
        else $error("watchdog or standby wrong");
    chk_rotate_flags: assert property (
        o_exec && o_op == OP_ROTATE_LEFT_VIA_CARRY |-> o_upd_c && !o_upd_z && !o_upd_dc)
        else $error("rotate flags wrong");

    cov_taken_skip:  cover property (o_exec && o_cond && i_cond_true);
    cov_call:        cover property (o_exec && o_op == OP_SUBROUTINE_CALL ##1 o_stall);
    cov_indirect:    cover property (o_exec && o_op == OP_INDIRECT_READ_ACC);
    cov_apb_status:  cover property (pready && paddr == APB_STATUS_OFFSET && !pslverr);

endmodule

// ==== verification/cid_prog_mem.sv ====
// program memory model: offers one instruction word per request
// assumes the bench pulses i_go for one cycle while o_valid is low
`timescale 1ns/1ps
module cid_prog_mem
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // request from bench, handshake with decoder
    input  wire logic        i_go,
    input  wire logic [13:0] i_word,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [13:0]      o_instr
);
    // once taken the bus is released: invert it so stale words never look valid
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_instr <= 14'h0000;
        end
        else if (o_valid && i_ready)
        begin
            o_valid <= 1'b0;
            o_instr <= ~o_instr;
        end
        else if (i_go && !o_valid)
        begin
            o_valid <= 1'b1;
            o_instr <= i_word;
        end
    end
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the instruction decoder
// assumes cid_pkg and cid_decoder; memory model in cid_prog_mem
`timescale 1ns/1ps
module tb;
    import cid_pkg::*;
    // fx = {ptr1 msb, ptr0 msb, skip true, extra cycles}
    typedef struct packed {logic [13:0] w; cid_op_t op; logic [4:0] fx;} cid_row_t;
    logic i_core_clk = 1'b0, i_rst = 1'b1, go = 1'b0, i_fsr0_msb = 1'b0, i_fsr1_msb = 1'b0, i_cond_true = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, o_ready, o_exec, o_stall, o_dest_file, pready, pslverr, e;
    logic [13:0] word = 14'h0000, instr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [5:0]  o_op;
    logic [6:0]  o_file_addr;
    logic [10:0] o_literal;
    logic [15:0] o_ptr_offset;
    logic [2:0]  o_bit_sel;
    logic [1:0]  o_ptr_mode;
    logic        o_ptr_sel, o_cond, o_upd_c, o_upd_dc, o_upd_z, o_upd_stat;
    logic        valid;
    int          mismatches = 0, samples_checked = 0;
    cid_row_t rows [39] = '{
        '{14'h3D10,OP_ADD_ACC_FILE_CARRY,5'h00}, '{14'h3790,OP_ARITH_SHIFT_RIGHT_FILE,5'h00},
        '{14'h0D10,OP_ROTATE_LEFT_VIA_CARRY,5'h00}, '{14'h0C90,OP_ROTATE_RIGHT_VIA_CARRY,5'h00},
        '{14'h0690,OP_XOR_ACC_FILE,5'h00}, '{14'h0B10,OP_DEC_SKIP_ZERO,5'h05},
        '{14'h0F90,OP_INC_SKIP_ZERO,5'h00}, '{14'h0F10,OP_INC_SKIP_ZERO,5'h05},
        '{14'h1810,OP_BIT_TEST_SKIP_CLEAR,5'h05}, '{14'h1C10,OP_BIT_TEST_SKIP_SET,5'h00},
        '{14'h1010,OP_BIT_CLEAR_FILE,5'h00}, '{14'h1590,OP_BIT_SET_FILE,5'h00},
        '{14'h3810,OP_OR_LITERAL_ACC,5'h00}, '{14'h3A10,OP_XOR_LITERAL_ACC,5'h00},
        '{14'h3C10,OP_SUB_ACC_FROM_LITERAL,5'h00}, '{14'h3190,OP_LOAD_PC_HIGH_LATCH,5'h00},
        '{14'h0030,OP_LOAD_BANK_SELECT,5'h00}, '{14'h3210,OP_RELATIVE_BRANCH,5'h01},
        '{14'h000B,OP_RELATIVE_BRANCH_ACC,5'h01}, '{14'h2010,OP_SUBROUTINE_CALL,5'h01},
        '{14'h2810,OP_ABSOLUTE_JUMP,5'h01}, '{14'h000A,OP_SUBROUTINE_CALL_ACC,5'h01},
        '{14'h0008,OP_SUB_RETURN,5'h01}, '{14'h0009,OP_INTERRUPT_RETURN,5'h01},
        '{14'h3410,OP_RETURN_WITH_LITERAL,5'h01}, '{14'h0064,OP_WATCHDOG_CLEAR,5'h00},
        '{14'h0063,OP_STANDBY,5'h00}, '{14'h0001,OP_SW_RESET,5'h00},
        '{14'h0000,OP_NO_OPERATION,5'h00}, '{14'h0062,OP_LOAD_OPTION,5'h00},
        '{14'h0065,OP_LOAD_PIN_DIRECTION,5'h00}, '{14'h3110,OP_POINTER_ADD_LITERAL,5'h00},
        '{14'h0010,OP_INDIRECT_READ_ACC,5'h00}, '{14'h3F90,OP_INDEXED_WRITE_ACC,5'h00},
        '{14'h3D00,OP_ADD_ACC_FILE_CARRY,5'h09}, '{14'h0B81,OP_DEC_SKIP_ZERO,5'h16},
        '{14'h0010,OP_INDIRECT_READ_ACC,5'h19}, '{14'h0018,OP_INDIRECT_WRITE_ACC,5'h00},
        '{14'h3F10,OP_INDEXED_READ_ACC,5'h00}};
    // ----------------------------------------
    // instances
    // ----------------------------------------
    cid_prog_mem u_mem (.i_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_word(word), .i_ready(o_ready),
        .o_valid(valid), .o_instr(instr));
    cid_decoder DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(valid), .i_instr(instr),
        .o_ready(o_ready), .i_fsr0_msb(i_fsr0_msb), .i_fsr1_msb(i_fsr1_msb), .i_cond_true(i_cond_true),
        .o_exec(o_exec), .o_stall(o_stall), .o_op(o_op), .o_dest_file(o_dest_file), .o_file_addr(o_file_addr),
        .o_bit_sel(o_bit_sel), .o_literal(o_literal), .o_ptr_sel(o_ptr_sel), .o_ptr_mode(o_ptr_mode),
        .o_ptr_offset(o_ptr_offset), .o_cond(o_cond), .o_upd_c(o_upd_c), .o_upd_dc(o_upd_dc), .o_upd_z(o_upd_z),
        .o_upd_stat(o_upd_stat), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial
    begin
        forever #20 i_core_clk = ~i_core_clk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // {carry, digit carry, zero, status, skip} that each op must raise
    function automatic logic [4:0] ctl(cid_op_t op);
        case (op)
            OP_ADD_ACC_FILE_CARRY, OP_SUB_ACC_FROM_LITERAL: return 5'h1C;
            OP_ARITH_SHIFT_RIGHT_FILE: return 5'h14;
            OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY: return 5'h10;
            OP_XOR_ACC_FILE, OP_OR_LITERAL_ACC, OP_XOR_LITERAL_ACC: return 5'h04;
            OP_INDIRECT_READ_ACC, OP_INDEXED_READ_ACC: return 5'h04;
            OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO, OP_BIT_TEST_SKIP_CLEAR, OP_BIT_TEST_SKIP_SET: return 5'h01;
            OP_WATCHDOG_CLEAR, OP_STANDBY: return 5'h02;
            default: return 5'h00;
        endcase
    endfunction
    // no fixed wait: pready is polled, the watchdog ends a hang
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge i_core_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do @(posedge i_core_clk); while (pready !== 1'b1);
        q = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic run(cid_row_t r);
        logic [13:0] w;
        int n;
        w = r.w | (r.w[4] ? ((r.w[13:5] == 9'h000 ? 14'h0007 : 14'h000F) & 14'($urandom)) : 14'h0000);
        @(posedge i_core_clk);
        word <= w; go <= 1'b1; i_cond_true <= r.fx[2]; i_fsr0_msb <= r.fx[3]; i_fsr1_msb <= r.fx[4];
        @(posedge i_core_clk);
        go <= 1'b0;
        do @(negedge i_core_clk); while (o_exec !== 1'b1);
        check("op", 32'(r.op), 32'(o_op));
        check("controls", 32'(ctl(r.op)), 32'({o_upd_c, o_upd_dc, o_upd_z, o_upd_stat, o_cond}));
        check("fields", {w[10:0], w[9:7], w[1:0], {10{w[5]}}, w[5:0]},
              {o_literal, o_bit_sel, o_ptr_mode, o_ptr_offset});
        if (r.op inside {OP_INDIRECT_READ_ACC, OP_INDIRECT_WRITE_ACC, OP_INDEXED_READ_ACC, OP_POINTER_ADD_LITERAL})
            check("pointer", 32'(r.w[13] ? w[6] : w[2]), 32'(o_ptr_sel));
        if (w[13:12] == 2'b00 && w[11:8] != 4'h0)
            check("dest", 32'({w[7], w[6:0]}), 32'({o_dest_file, o_file_addr}));
        n = 0;
        repeat (6) begin @(negedge i_core_clk); if (o_stall === 1'b1) n++; end
        check("extra cycles", 32'(r.fx[1:0]), 32'(n));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(25));
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0); check("ctrl reset", 32'h0000_0001, q);
        repeat (3) foreach (rows[i]) run(rows[i]);
        run(rows[20]);
        apb(1'b0, 12'h004, 32'h0); check("status", {22'h0, 2'h2, 2'h0, 6'(OP_ABSOLUTE_JUMP)}, q);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0); check("ctrl off", 32'h0, q);
        run('{14'h2810, OP_NO_OPERATION, 5'h00});
        apb(1'b1, 12'h000, 32'h1);
        run('{14'h0002, OP_NO_OPERATION, 5'h00});
        apb(1'b0, 12'h008, 32'h0); check("unmapped err", 32'h1, 32'(e)); check("unmapped data", 32'h0, q);
        conclude();
    end
    initial
    begin
        #(40 * 20000);
        mismatches++;
        conclude();
    end
endmodule
